// File: inc/cct_pkg.sv
// cct_pkg: register map, field positions, reset values and bus carriers
// for the capture/compare timer; assumes a 32-bit AXI4-Lite register bus.
`default_nettype none
package cct_pkg;
  localparam int AW = 8;
  // byte addresses of the byte-wide registers, one aligned word each
  localparam logic [AW-1:0] OFS_CTRL1  = 8'h00;
  localparam logic [AW-1:0] OFS_CTRL2  = 8'h04;
  localparam logic [AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [AW-1:0] OFS_CNT_HI = 8'h0c;
  localparam logic [AW-1:0] OFS_CNT_LO = 8'h10;
  localparam logic [AW-1:0] OFS_SHD_HI = 8'h14;
  localparam logic [AW-1:0] OFS_SHD_LO = 8'h18;
  localparam logic [AW-1:0] OFS_CAP1_HI = 8'h1c;
  localparam logic [AW-1:0] OFS_CAP1_LO = 8'h20;
  localparam logic [AW-1:0] OFS_CAP2_HI = 8'h24;
  localparam logic [AW-1:0] OFS_CAP2_LO = 8'h28;
  localparam logic [AW-1:0] OFS_CMP1_HI = 8'h2c;
  localparam logic [AW-1:0] OFS_CMP1_LO = 8'h30;
  localparam logic [AW-1:0] OFS_CMP2_HI = 8'h34;
  localparam logic [AW-1:0] OFS_CMP2_LO = 8'h38;
  localparam logic [AW-1:0] OFS_LAST    = 8'h38;
  // control one fields
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_LVL2      = 2;
  localparam int C1_CAP_EDGE1 = 1;
  localparam int C1_LVL1      = 0;
  // control two fields
  localparam int C2_PIN_EN1 = 7;
  localparam int C2_PIN_EN2 = 6;
  localparam int C2_OPM    = 5;
  localparam int C2_PWM    = 4;
  localparam int C2_CS_HI  = 3;
  localparam int C2_CS_LO  = 2;
  localparam int C2_CAP_EDGE2 = 1;
  localparam int C2_EXT_EDGE  = 0;
  // status fields
  localparam int ST_CAPF1 = 7;
  localparam int ST_CMPF1 = 6;
  localparam int ST_OVF   = 5;
  localparam int ST_CAPF2 = 4;
  localparam int ST_CMPF2 = 3;
  // clock select codes
  localparam logic [1:0] CS_DIV2 = 2'h0;
  localparam logic [1:0] CS_DIV4 = 2'h1;
  localparam logic [1:0] CS_DIV8 = 2'h2;
  localparam logic [1:0] CS_EXT  = 2'h3;
  // reset values, counter top value and bus response codes
  localparam logic [15:0] CNT_RESET  = 16'hfffc;
  localparam logic [15:0] CNT_TOP    = 16'hffff;
  localparam logic [15:0] CMP_RESET  = 16'h8000;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } cct_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cct_axi_rsp_t;
endpackage : cct_pkg
`default_nettype wire

// File: rtl/cct_pin_sync.sv
// cct_pin_sync: two-flop synchroniser plus one delay stage for edge detection
// assumes asynchronous pin inputs; outputs are on clk.
`default_nettype none
module cct_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinAsync,
  output logic      [W-1:0] pinSync,
  output logic      [W-1:0] pinSyncDly
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r     <= '0;
      pinSync    <= '0;
      pinSyncDly <= '0;
    end else begin
      meta_r     <= pinAsync;
      pinSync    <= meta_r;
      pinSyncDly <= pinSync;
    end
  end
endmodule : cct_pin_sync
`default_nettype wire

// File: rtl/cct_timer16.sv
// cct_timer16: 16-bit free-running timer, two captures, two compares,
// byte-wide registers on an AXI4-Lite slave; pins are asynchronous.
//
// Chosen here: the AXI4-Lite register port and the address map.
`default_nettype none
module cct_timer16 (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire cct_pkg::cct_axi_req_t axiReq,
  output cct_pkg::cct_axi_rsp_t      axiRsp,
  input  wire logic [1:0]           capture_input_pin,
  input  wire logic                 ext_timer_clock_pin,
  input  wire logic                 haltMode,
  input  wire logic                 globalIrqMask,
  output logic      [1:0]           compare_output_pin,
  output logic                      timerIrq
);
  import cct_pkg::*;

  function automatic logic isMapped(input logic [AW-1:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_LAST);
  endfunction : isMapped

  logic [1:0] capSync;
  logic [1:0] capSyncDly;
  logic       extSync;
  logic       extSyncDly;

  // capture pins are read here regardless of any port direction setting
  cct_pin_sync #(.W(3)) u_sync (
    .clk        (clk),
    .rst        (rst),
    .pinAsync   ({ext_timer_clock_pin, capture_input_pin}),
    .pinSync    ({extSync, capSync}),
    .pinSyncDly ({extSyncDly, capSyncDly})
  );

  // register state
  logic [7:0]  ctrl1_r,    ctrl1_nxt;
  logic [7:0]  ctrl2_r,    ctrl2_nxt;
  logic [2:0]  psc_r,      psc_nxt;
  logic [15:0] cnt_r,      cnt_nxt;
  logic [7:0]  latch_r,    latch_nxt;
  logic        latchVld_r, latchVld_nxt;
  logic [15:0] cap_r [2],  cap_nxt [2];
  logic [1:0]  capHold_r,  capHold_nxt;
  logic [15:0] cmp_r [2],  cmp_nxt [2];
  logic [1:0]  cmpArm_r,   cmpArm_nxt;
  logic [1:0]  icf_r,      icf_nxt;
  logic [1:0]  ocf_r,      ocf_nxt;
  logic        ovf_r,      ovf_nxt;
  logic [1:0]  icfClr_r,   icfClr_nxt;
  logic [1:0]  ocfClr_r,   ocfClr_nxt;
  logic        ovfClr_r,   ovfClr_nxt;
  logic [1:0]  pin_r,      pin_nxt;
  logic        irq_r,      irq_nxt;
  // bus state
  logic        awReady_r,  awReady_nxt;
  logic        bValid_r,   bValid_nxt;
  logic [1:0]  bResp_r,    bResp_nxt;
  logic        arReady_r,  arReady_nxt;
  logic        rValid_r,   rValid_nxt;
  logic [7:0]  rData_r,    rData_nxt;
  logic [1:0]  rResp_r,    rResp_nxt;

  // combinational helpers
  logic          wrHit, rdHit, wrEn, rdEn;
  logic [AW-1:0] wa, ra;
  logic [7:0]    wd, rdByte;
  logic          tick, extEdge;
  logic [1:0]    capEdge, capAllow, cmpHit, olvl, pinEn;
  logic [1:0]    capLoAcc, cmpLoAcc, capHiRd, capLoRd;
  logic          cntLoAcc, stRd, mode2;
  logic [7:0]    status;

  always_comb begin
    ctrl1_nxt    = ctrl1_r;
    ctrl2_nxt    = ctrl2_r;
    cnt_nxt      = cnt_r;
    latch_nxt    = latch_r;
    latchVld_nxt = latchVld_r;
    cap_nxt      = cap_r;
    capHold_nxt  = capHold_r;
    cmp_nxt      = cmp_r;
    cmpArm_nxt   = cmpArm_r;
    pin_nxt      = pin_r;
    rdByte       = 8'h00;

    // bus handshakes: ready is a one-cycle pulse while valid is held
    wa    = axiReq.awaddr;
    ra    = axiReq.araddr;
    wd    = axiReq.wdata[7:0];
    wrHit = awReady_r && axiReq.awvalid && axiReq.wvalid;
    rdHit = arReady_r && axiReq.arvalid;
    wrEn  = wrHit && axiReq.wstrb[0] && isMapped(wa);
    rdEn  = rdHit && isMapped(ra);

    awReady_nxt = axiReq.awvalid && axiReq.wvalid && !awReady_r && !bValid_r;
    bValid_nxt  = wrHit ? 1'b1 : (bValid_r && !axiReq.bready);
    bResp_nxt   = wrHit ? (isMapped(wa) ? RESP_OKAY : RESP_SLVERR) : bResp_r;
    arReady_nxt = axiReq.arvalid && !arReady_r && !rValid_r;
    rValid_nxt  = rdHit ? 1'b1 : (rValid_r && !axiReq.rready);
    rResp_nxt   = rdHit ? (isMapped(ra) ? RESP_OKAY : RESP_SLVERR) : rResp_r;

    // access classification
    stRd        = rdEn && ra == OFS_STATUS;
    cntLoAcc    = (wrEn && wa == OFS_CNT_LO) || (rdEn && ra == OFS_CNT_LO);
    capHiRd[0]  = rdEn && ra == OFS_CAP1_HI;
    capHiRd[1]  = rdEn && ra == OFS_CAP2_HI;
    capLoRd[0]  = rdEn && ra == OFS_CAP1_LO;
    capLoRd[1]  = rdEn && ra == OFS_CAP2_LO;
    capLoAcc[0] = capLoRd[0] || (wrEn && wa == OFS_CAP1_LO);
    capLoAcc[1] = capLoRd[1] || (wrEn && wa == OFS_CAP2_LO);
    cmpLoAcc[0] = (rdEn && ra == OFS_CMP1_LO) || (wrEn && wa == OFS_CMP1_LO);
    cmpLoAcc[1] = (rdEn && ra == OFS_CMP2_LO) || (wrEn && wa == OFS_CMP2_LO);

    // timer clock generation
    psc_nxt = psc_r + 3'h1;
    extEdge = ctrl2_r[C2_EXT_EDGE] ? (extSync && !extSyncDly)
                                : (!extSync && extSyncDly);
    unique case (ctrl2_r[C2_CS_HI:C2_CS_LO])
      CS_DIV2: tick = psc_r[0];
      CS_DIV4: tick = &psc_r[1:0];
      CS_DIV8: tick = &psc_r;
      CS_EXT:  tick = extEdge;
    endcase
    if (haltMode) begin
      tick    = 1'b0;
      psc_nxt = psc_r;
    end

    // free-running counter
    if (tick) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (wrEn && (wa == OFS_CNT_LO || wa == OFS_SHD_LO)) begin
      cnt_nxt = CNT_RESET;
    end

    // capture
    mode2       = ctrl2_r[C2_OPM] || ctrl2_r[C2_PWM];
    capAllow[0] = !mode2;
    capAllow[1] = 1'b1;
    capEdge[0]  = ctrl1_r[C1_CAP_EDGE1] ? (capSync[0] && !capSyncDly[0])
                                    : (!capSync[0] && capSyncDly[0]);
    capEdge[1]  = ctrl2_r[C2_CAP_EDGE2] ? (capSync[1] && !capSyncDly[1])
                                    : (!capSync[1] && capSyncDly[1]);
    for (int i = 0; i < 2; i++) begin
      capEdge[i] = capEdge[i] && capAllow[i] && !capHold_r[i];
      if (capEdge[i]) begin
        cap_nxt[i] = cnt_r;
      end
      if (capHiRd[i]) begin
        capHold_nxt[i] = 1'b1;
      end else if (capLoRd[i]) begin
        capHold_nxt[i] = 1'b0;
      end
    end

    // compare
    olvl  = {ctrl1_r[C1_LVL2], ctrl1_r[C1_LVL1]};
    pinEn = {ctrl2_r[C2_PIN_EN2], ctrl2_r[C2_PIN_EN1]};
    for (int i = 0; i < 2; i++) begin
      cmpHit[i] = tick && cmpArm_r[i] && (cnt_r == cmp_r[i]);
      if (cmpHit[i] && pinEn[i]) begin
        pin_nxt[i] = olvl[i];
      end
    end

    // register writes
    if (wrEn) begin
      unique case (wa)
        OFS_CTRL1:   ctrl1_nxt = wd;
        OFS_CTRL2:   ctrl2_nxt = wd;
        OFS_CMP1_HI: begin
          cmp_nxt[0][15:8] = wd;
          cmpArm_nxt[0]    = 1'b0;
        end
        OFS_CMP1_LO: begin
          cmp_nxt[0][7:0] = wd;
          cmpArm_nxt[0]   = 1'b1;
        end
        OFS_CMP2_HI: begin
          cmp_nxt[1][15:8] = wd;
          cmpArm_nxt[1]    = 1'b0;
        end
        OFS_CMP2_LO: begin
          cmp_nxt[1][7:0] = wd;
          cmpArm_nxt[1]   = 1'b1;
        end
        default: ;
      endcase
    end

    // register reads
    status = 8'h00;
    status[ST_CAPF1] = icf_r[0];
    status[ST_CMPF1] = ocf_r[0];
    status[ST_OVF]   = ovf_r;
    status[ST_CAPF2] = icf_r[1];
    status[ST_CMPF2] = ocf_r[1];
    if (rdEn) begin
      unique case (ra)
        OFS_CTRL1:   rdByte = ctrl1_r;
        OFS_CTRL2:   rdByte = ctrl2_r;
        OFS_STATUS:  rdByte = status;
        OFS_CNT_HI, OFS_SHD_HI: begin
          rdByte = cnt_r[15:8];
          if (!latchVld_r) begin
            latch_nxt    = cnt_r[7:0];
            latchVld_nxt = 1'b1;
          end
        end
        OFS_CNT_LO, OFS_SHD_LO: begin
          rdByte       = latchVld_r ? latch_r : cnt_r[7:0];
          latchVld_nxt = 1'b0;
        end
        OFS_CAP1_HI: rdByte = cap_r[0][15:8];
        OFS_CAP1_LO: rdByte = cap_r[0][7:0];
        OFS_CAP2_HI: rdByte = cap_r[1][15:8];
        OFS_CAP2_LO: rdByte = cap_r[1][7:0];
        OFS_CMP1_HI: rdByte = cmp_r[0][15:8];
        OFS_CMP1_LO: rdByte = cmp_r[0][7:0];
        OFS_CMP2_HI: rdByte = cmp_r[1][15:8];
        OFS_CMP2_LO: rdByte = cmp_r[1][7:0];
        default:     rdByte = 8'h00;
      endcase
    end
    rData_nxt = rdHit ? rdByte : rData_r;
  end

  // status flags: two-step clear, a new event in the clearing cycle wins
  always_comb begin
    ovfClr_nxt = ovfClr_r;
    icfClr_nxt = icfClr_r;
    ocfClr_nxt = ocfClr_r;
    ovf_nxt    = ovf_r;
    icf_nxt    = icf_r;
    ocf_nxt    = ocf_r;

    if (ovfClr_r && cntLoAcc) begin
      ovf_nxt    = 1'b0;
      ovfClr_nxt = 1'b0;
    end
    if (stRd && ovf_r) begin
      ovfClr_nxt = 1'b1;
    end
    if (tick && cnt_r == CNT_TOP) begin
      ovf_nxt = 1'b1;
    end

    for (int i = 0; i < 2; i++) begin
      if (icfClr_r[i] && capLoAcc[i]) begin
        icf_nxt[i]    = 1'b0;
        icfClr_nxt[i] = 1'b0;
      end
      if (stRd && icf_r[i]) begin
        icfClr_nxt[i] = 1'b1;
      end
      if (capEdge[i]) begin
        icf_nxt[i] = 1'b1;
      end

      if (ocfClr_r[i] && cmpLoAcc[i]) begin
        ocf_nxt[i]    = 1'b0;
        ocfClr_nxt[i] = 1'b0;
      end
      if (stRd && ocf_r[i]) begin
        ocfClr_nxt[i] = 1'b1;
      end
      if (cmpHit[i]) begin
        ocf_nxt[i] = 1'b1;
      end
    end

    // request stays pending in the flags until enable and mask allow it
    irq_nxt = !globalIrqMask && (
                (ovf_r && ctrl1_r[C1_OVF_IE]) ||
                ((|icf_r) && ctrl1_r[C1_CAP_IE]) ||
                ((|ocf_r) && ctrl1_r[C1_CMP_IE]));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1_r    <= CTRL_RESET;
      ctrl2_r    <= CTRL_RESET;
      psc_r      <= 3'h0;
      cnt_r      <= CNT_RESET;
      latch_r    <= 8'h00;
      latchVld_r <= 1'b0;
      cap_r[0]   <= 16'h0000;
      cap_r[1]   <= 16'h0000;
      capHold_r  <= 2'h0;
      cmp_r[0]   <= CMP_RESET;
      cmp_r[1]   <= CMP_RESET;
      cmpArm_r   <= 2'h3;
      icf_r      <= 2'h0;
      ocf_r      <= 2'h0;
      ovf_r      <= 1'b0;
      icfClr_r   <= 2'h0;
      ocfClr_r   <= 2'h0;
      ovfClr_r   <= 1'b0;
      pin_r      <= 2'h0;
      irq_r      <= 1'b0;
      awReady_r  <= 1'b0;
      bValid_r   <= 1'b0;
      bResp_r    <= RESP_OKAY;
      arReady_r  <= 1'b0;
      rValid_r   <= 1'b0;
      rData_r    <= 8'h00;
      rResp_r    <= RESP_OKAY;
    end else begin
      ctrl1_r    <= ctrl1_nxt;
      ctrl2_r    <= ctrl2_nxt;
      psc_r      <= psc_nxt;
      cnt_r      <= cnt_nxt;
      latch_r    <= latch_nxt;
      latchVld_r <= latchVld_nxt;
      cap_r      <= cap_nxt;
      capHold_r  <= capHold_nxt;
      cmp_r      <= cmp_nxt;
      cmpArm_r   <= cmpArm_nxt;
      icf_r      <= icf_nxt;
      ocf_r      <= ocf_nxt;
      ovf_r      <= ovf_nxt;
      icfClr_r   <= icfClr_nxt;
      ocfClr_r   <= ocfClr_nxt;
      ovfClr_r   <= ovfClr_nxt;
      pin_r      <= pin_nxt;
      irq_r      <= irq_nxt;
      awReady_r  <= awReady_nxt;
      bValid_r   <= bValid_nxt;
      bResp_r    <= bResp_nxt;
      arReady_r  <= arReady_nxt;
      rValid_r   <= rValid_nxt;
      rData_r    <= rData_nxt;
      rResp_r    <= rResp_nxt;
    end
  end

  always_comb begin
    axiRsp         = '0;
    axiRsp.awready = awReady_r;
    axiRsp.wready  = awReady_r;
    axiRsp.bvalid  = bValid_r;
    axiRsp.bresp   = bResp_r;
    axiRsp.arready = arReady_r;
    axiRsp.rvalid  = rValid_r;
    axiRsp.rdata   = {24'h000000, rData_r};
    axiRsp.rresp   = rResp_r;
  end

  assign compare_output_pin = pin_r;
  assign timerIrq           = irq_r;
endmodule : cct_timer16
`default_nettype wire

// File: test/cct_timer16_props.sv
// cct_timer16_props: port-level checks for the capture/compare timer
// assumes one clk domain and a synchronous active-high rst
`default_nettype none
module cct_timer16_props
  import cct_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire cct_axi_req_t axiReq,
  input wire cct_axi_rsp_t axiRsp,
  input wire logic         globalIrqMask,
  input wire logic [1:0]   compare_output_pin,
  input wire logic         timerIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_mask; globalIrqMask |=> !timerIrq; endproperty
  a_mask: assert property (p_mask) else $error("irq seen while masked");
  property p_rise; $rose(timerIrq) |-> !$past(globalIrqMask); endproperty
  a_rise: assert property (p_rise) else $error("irq rose under mask");
  // a raised request only drops after a bus access or a mask
  property p_pend;
    timerIrq && !globalIrqMask && !axiReq.arvalid && !axiReq.awvalid
      && !$past(axiReq.arvalid) && !$past(axiReq.awvalid) |=> timerIrq;
  endproperty
  a_pend: assert property (p_pend) else $error("irq dropped without access");
  property p_pinrst; disable iff (1'b0) rst |=> compare_output_pin == 2'h0; endproperty
  a_pinrst: assert property (p_pinrst) else $error("compare pin not low in reset");
  property p_wr;
    axiReq.awvalid && axiReq.wvalid && !axiRsp.awready && !axiRsp.bvalid
      |=> axiRsp.awready && axiRsp.wready ##1 axiRsp.bvalid && !axiRsp.awready;
  endproperty
  a_wr: assert property (p_wr) else $error("write not answered in time");
  property p_rd; axiReq.arvalid && !axiRsp.arready && !axiRsp.rvalid |=> axiRsp.arready ##1 axiRsp.rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered in time");
  property p_rhold; axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_bhold; axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");
  property p_err;
    axiReq.arvalid && axiReq.araddr > OFS_LAST && !axiRsp.arready && !axiRsp.rvalid
      |=> ##1 axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped read not refused");
  c_irq: cover property ($rose(timerIrq));
  c_pin: cover property ($changed(compare_output_pin));
  c_err: cover property (axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR);
endmodule : cct_timer16_props
`default_nettype wire

// File: test/cct_pin_model.sv
// cct_pin_model: far side pins: capture inputs and external timer clock
// assumes clk is the timer clock; drives just after rising edges
`default_nettype none
module cct_pin_model (
  input  wire logic       clk,
  output logic      [1:0] capPin,
  output logic            extPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    capPin = 2'h0;
    extPin = 1'b0;
  end
  // one edge on a capture pin, then room for sync and capture
  task automatic toggle(input int ch);
    capPin[ch] <= ~capPin[ch];
    repeat (6) @(posedge clk);
  endtask : toggle
  // full pulses, each half four cycles so the rate stays below clk/4
  task automatic ext_pulses(input int n);
    repeat (n) begin
      extPin <= 1'b1;
      repeat (4) @(posedge clk);
      extPin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : ext_pulses
endmodule : cct_pin_model
`default_nettype wire

// File: test/cct_timer16_tb.sv
// cct_timer16_tb: self-checking bench for the capture/compare timer
// assumes cct_pkg, cct_pin_model and cct_timer16_props are compiled first
`default_nettype none
module cct_timer16_tb;
  import cct_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         halt = 1'b1;
  logic         mask = 1'b1;
  cct_axi_req_t req = '0;
  cct_axi_rsp_t rsp;
  logic [1:0]   capPin;
  logic         extPin;
  logic [1:0]   cmpPin;
  logic         irq;
  logic [15:0]  v;
  logic [7:0]   d;
  logic [1:0]   resp;
  int           errorCnt = 0;
  int           totalChecks = 0;
  always #25 clk = ~clk;
  cct_timer16 i_cct_timer16 (.clk(clk), .rst(rst), .axiReq(req), .axiRsp(rsp),
    .capture_input_pin(capPin), .ext_timer_clock_pin(extPin), .haltMode(halt),
    .globalIrqMask(mask), .compare_output_pin(cmpPin), .timerIrq(irq));
  cct_pin_model i_cct_pin_model (.clk(clk), .capPin(capPin), .extPin(extPin));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  // upper data bits are junk on purpose: only bits 7:0 may land
  task automatic wr(input logic [7:0] a, input logic [7:0] x, input logic [3:0] s = 4'hf);
    req.awaddr <= a;
    req.wdata <= {24'ha5a5a5, x};
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) begin
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (!rsp.bvalid);
    req.bready <= 1'b1;
    @(posedge clk);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] x, output logic [1:0] r);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b1;
    @(posedge clk);
    x = rsp.rdata[7:0];
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, d, resp);
    chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, d});
  endtask : rc
  task automatic rd16(input logic [7:0] a);
    logic [7:0] h;
    rd(a, h, resp);
    rd(a + 8'h04, d, resp);
    v = {h, d};
  endtask : rd16
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic t_reset;
    rd16(OFS_CNT_HI);
    chk("count", CNT_RESET, v);
    rd16(OFS_SHD_HI);
    chk("shadow", CNT_RESET, v);
    rc(OFS_CMP1_HI, 8'h80);
    rc(OFS_CMP1_LO, 8'h00);
    rc(OFS_CMP2_HI, 8'h80);
    rc(OFS_CMP2_LO, 8'h00);
    chk("cmpPin", 16'h0, {14'h0, cmpPin});
  endtask : t_reset
  task automatic t_overflow;
    halt <= 1'b0;
    wt(20);
    rc(OFS_STATUS, 8'h20);
    rd(OFS_SHD_LO, d, resp);
    rc(OFS_STATUS, 8'h20);
    rd(OFS_CNT_LO, d, resp);
    rc(OFS_STATUS, 8'h00);
    wr(OFS_CNT_LO, 8'h00);
    wt(20);
    rd(OFS_CNT_LO, d, resp);
    rc(OFS_STATUS, 8'h20);
  endtask : t_overflow
  task automatic t_latch;
    halt <= 1'b1;
    wr(OFS_SHD_LO, 8'h00);
    rc(OFS_CNT_HI, 8'hff);
    halt <= 1'b0;
    wt(6);
    halt <= 1'b1;
    rc(OFS_SHD_HI, 8'hff);
    rc(OFS_SHD_LO, 8'hfc);
    rc(OFS_CNT_LO, 8'hff);
  endtask : t_latch
  task automatic t_clock;
    logic [1:0] cs [3] = '{CS_DIV2, CS_DIV4, CS_DIV8};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL2, {4'h0, cs[i], 2'h0});
      wr(OFS_CNT_LO, 8'h00);
      halt <= 1'b0;
      wt(32);
      halt <= 1'b1;
      rd16(OFS_CNT_HI);
      chk("count", 16'hfffc + (16'd32 >> (i + 1)), v);
    end
    halt <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL2, {4'h0, CS_EXT, 1'b0, i == 0});
      wr(OFS_CNT_LO, 8'h00);
      i_cct_pin_model.ext_pulses(5 - 2 * i);
      rd16(OFS_CNT_HI);
      chk("ext count", i == 0 ? 16'h0001 : 16'hffff, v);
    end
    halt <= 1'b1;
  endtask : t_clock
  task automatic t_compare;
    rd(OFS_STATUS, d, resp);
    wr(OFS_CNT_LO, 8'h00);
    wr(OFS_CTRL2, 8'hc0);
    wr(OFS_CMP1_HI, 8'h00);
    wr(OFS_CMP1_LO, 8'h02);
    wr(OFS_CMP2_HI, 8'hff);
    wr(OFS_CMP2_LO, 8'hfe);
    wr(OFS_CTRL1, 8'h45);
    halt <= 1'b0;
    wt(16);
    halt <= 1'b1;
    chk("cmpPin", 16'h3, {14'h0, cmpPin});
    chk("irq", 16'h0, {15'h0, irq});
    mask <= 1'b0;
    wt(2);
    chk("irq", 16'h1, {15'h0, irq});
    rc(OFS_STATUS, 8'h68);
    rc(OFS_CMP1_HI, 8'h00);
    rc(OFS_CMP1_LO, 8'h02);
    rc(OFS_CMP2_LO, 8'hfe);
    rc(OFS_STATUS, 8'h20);
    chk("irq", 16'h0, {15'h0, irq});
    wr(OFS_CTRL1, 8'h20);
    wt(2);
    chk("irq", 16'h1, {15'h0, irq});
    mask <= 1'b1;
    wt(2);
    chk("irq", 16'h0, {15'h0, irq});
    mask <= 1'b0;
    rd(OFS_CNT_LO, d, resp);
    chk("irq", 16'h0, {15'h0, irq});
  endtask : t_compare
  task automatic t_capture;
    mask <= 1'b1;
    wr(OFS_CNT_LO, 8'h00);
    wr(OFS_CTRL2, 8'h00);
    wr(OFS_CTRL1, 8'h82);
    i_cct_pin_model.toggle(0);
    i_cct_pin_model.toggle(1);
    rc(OFS_STATUS, 8'h80);
    i_cct_pin_model.toggle(1);
    rc(OFS_STATUS, 8'h90);
    rc(OFS_CAP1_HI, 8'hff);
    rc(OFS_CAP1_LO, 8'hfc);
    rc(OFS_CAP2_HI, 8'hff);
    halt <= 1'b0;
    wt(4);
    halt <= 1'b1;
    i_cct_pin_model.toggle(1);
    i_cct_pin_model.toggle(1);
    rc(OFS_STATUS, 8'h10);
    rc(OFS_CAP2_LO, 8'hfc);
    rc(OFS_STATUS, 8'h00);
    wr(OFS_CTRL2, 8'h20);
    i_cct_pin_model.toggle(0);
    i_cct_pin_model.toggle(0);
    i_cct_pin_model.toggle(1);
    i_cct_pin_model.toggle(1);
    rc(OFS_STATUS, 8'h10);
    chk("irq", 16'h0, {15'h0, irq});
    mask <= 1'b0;
    wt(2);
    chk("irq", 16'h1, {15'h0, irq});
  endtask : t_capture
  task automatic t_bus;
    rd(8'h3c, d, resp);
    chk("resp", {14'h0, RESP_SLVERR}, {14'h0, resp});
    chk("rdata", 16'h0, {8'h0, d});
    rd(8'h09, d, resp);
    chk("resp", {14'h0, RESP_SLVERR}, {14'h0, resp});
    // a write without the low byte lane must leave the register alone
    wr(OFS_CTRL1, 8'h00, 4'he);
    chk("bresp", {14'h0, RESP_OKAY}, {14'h0, resp});
    rc(OFS_CTRL1, 8'h82);
  endtask : t_bus
  task automatic end_of_test;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    wt(3);
    rst <= 1'b0;
    wt(1);
    t_reset;
    t_overflow;
    t_latch;
    t_clock;
    t_compare;
    t_capture;
    t_bus;
    end_of_test;
  end
  initial begin
    wt(20000);
    errorCnt++;
    end_of_test;
  end
endmodule : cct_timer16_tb
bind cct_timer16 cct_timer16_props i_cct_timer16_props (.clk(clk), .rst(rst), .axiReq(axiReq),
  .axiRsp(axiRsp), .globalIrqMask(globalIrqMask), .compare_output_pin(compare_output_pin), .timerIrq(timerIrq));
`default_nettype wire
